// [prs_pkg.sv]
// Package for the PLL reference switch and divider block.
// Assumes a single 200 MHz system clock and byte-wide register writes.
package prs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses and reset value.
  localparam logic [9:0] REF_DIV_LOW_ADDR = 10'h011;
  localparam logic [9:0] REF_DIV_HIGH_ADDR = 10'h012;
  localparam logic [9:0] PRESCALER_CFG_ADDR = 10'h016;
  localparam logic [9:0] LOCK_OFFSET_CFG_ADDR = 10'h018;
  localparam logic [9:0] REF_INPUT_CTRL_ADDR = 10'h01c;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int RC_PRIMARY_EN = 0;
  localparam int RC_SECONDARY_EN = 1;
  localparam int RC_DIFF_EN = 2;
  localparam int RC_NONREVERTIVE = 3;
  localparam int RC_AUTO = 4;
  localparam int RC_MANUAL_SECONDARY = 5;
  localparam int RC_CRYSTAL_EN = 6;
  localparam int RC_DEGLITCH_OFF = 7;
  localparam int PS_MODE_LSB = 0;
  localparam int PS_RST_REF = 5;
  localparam int PS_RST_FB = 6;
  localparam int PS_RST_SHARED = 7;
  localparam int LO_DC_OFFSET = 7;
  localparam int REF_DIV_HIGH_BITS = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Edge counts of the switchover monitor and the minimum main count.
  localparam logic [1:0] MISS_FALLS = 2'h2;
  localparam logic [1:0] REVERT_BREAK_FALLS = 2'h2;
  localparam logic [2:0] RETURN_RISES = 3'h4;
  localparam logic [12:0] MIN_MAIN_COUNT = 13'h0003;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler settings.
  typedef enum logic [2:0] {
    PS_DM_2 = 3'b000,
    PS_DM_4 = 3'b001,
    PS_DM_8 = 3'b010,
    PS_DM_16 = 3'b011,
    PS_DM_32 = 3'b100,
    PS_FD_1 = 3'b101,
    PS_FD_2 = 3'b110,
    PS_FD_3 = 3'b111
  } prs_prescale_t;

  typedef enum logic [1:0] {
    SW_PRIMARY = 2'b00,
    SW_MISSING = 2'b01,
    SW_SECONDARY = 2'b10
  } prs_sw_state_t;

endpackage

// [prs_div_if.sv]
// Interface between the control logic and one divide-by-ratio counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface prs_div_if #(parameter int W = 14);
  logic tick;
  logic clr;
  logic [W-1:0] ratio;
  logic pulse;
  modport ctl (output tick, output clr, output ratio, input pulse);
  modport cnt (input tick, input clr, input ratio, output pulse);
endinterface

// [prs_divider.sv]
// Divide-by-ratio counter used for both the reference and the feedback path.
// Assumes tick is a one-cycle pulse per input clock edge on the same clock.
`timescale 1ns/1ps
module prs_divider #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  prs_div_if.cnt div
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic pulse;
  } prs_div_state_t;

  prs_div_state_t state_q;
  prs_div_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Ratios of zero and one both divide by one.
  always_comb
  begin
    state_d = state_q;
    state_d.pulse = 1'b0;
    if (div.clr)
    begin
      state_d.cnt = '0;
    end
    else if (div.tick)
    begin
      if (({1'b0, state_q.cnt} + (W + 1)'(1)) >= {1'b0, div.ratio})
      begin
        state_d.cnt = '0;
        state_d.pulse = 1'b1;
      end
      else
      begin
        state_d.cnt = state_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign div.pulse = state_q.pulse;

endmodule // prs_divider

// [prs_ref_switch.sv]
// Reference input control, switchover and R and N dividers of the PLL.
// Assumes reference and VCO pins are far slower than the 200 MHz clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Function
// - All reference inputs off after reset.
// - Differential receiver off unless selected, PLL on.
// - Single-ended buffers off by control, PLL, differential.
// - Offset bit lowers single-ended bias point.
// - Crystal bit enables maintaining amplifier.
// - Switching only in dual single-ended mode.
// - Manual select from register or pin.
// - Revertive and nonrevertive automatic policies.
// - Two secondary falls without primary edge: missing.
// - Secondary takes over at next rising edge.
// - Revert after four clean primary rising edges.
// - Deglitch blocks misaligned edges during switch.
// - Fourteen-bit reference divider across two registers.
// - Reference settings zero and one divide by one.
// - Reference divider reset by own, shared, sync.
// - Feedback ratio is modulus times main plus swallow.
// - Prescaler fixed and dual-modulus settings, 3-bit field.
// - Fixed-divide settings treat swallow count as zero.
// - Feedback ratio spans one to 262175.
// - Main count at least three unless bypassed; swallow below main.
// - Counter reset bits are not self-clearing.
module prs_ref_switch #(
  parameter int R_BITS = 14,
  parameter int N_BITS = 19,
  parameter int A_BITS = 6,
  parameter int B_BITS = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic primary_reference,
  input wire logic secondary_reference,
  input wire logic vco_in,
  input wire logic ref_select_pin,
  input wire logic sync_n,
  input wire logic sync_reset_enable,
  input wire logic pll_power_down,
  input wire logic [A_BITS-1:0] swallow_count,
  input wire logic [B_BITS-1:0] main_count,
  input wire logic main_bypass,
  output logic diff_receiver_power_on,
  output logic primary_buffer_power_on,
  output logic secondary_buffer_power_on,
  output logic crystal_amplifier_enable,
  output logic dc_offset_shift,
  output logic phase_detector_ref,
  output logic phase_detector_fb,
  output logic secondary_in_use,
  output logic primary_missing
);

  localparam int NPIN = 5;
  localparam int PIN_PRI = 0;
  localparam int PIN_SEC = 1;
  localparam int PIN_VCO = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_SYNC = 4;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] lvl;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] prescale_cfg;
    logic [7:0] offset_cfg;
    logic [7:0] ref_ctrl;
    logic [7:0] rdata;
    prs_pkg::prs_sw_state_t sw;
    logic [1:0] miss_falls;
    logic [1:0] break_falls;
    logic [2:0] return_rises;
    logic active_secondary;
    logic [N_BITS-1:0] fb_ratio;
    logic diff_on;
    logic pri_on;
    logic sec_on;
    logic xtal_on;
    logic offset_on;
  } prs_state_t;

  prs_state_t state_q;
  prs_state_t state_d;

  prs_div_if #(.W(R_BITS)) ref_div ();
  prs_div_if #(.W(N_BITS)) fb_div ();

  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic pll_on;
  logic dual_se;
  logic auto_mode;
  logic target_secondary;
  logic new_ref_rise;
  logic sync_reset;
  logic [5:0] modulus;
  logic fixed_divide;
  logic [B_BITS-1:0] main_eff;
  logic [A_BITS-1:0] swallow_eff;
  logic [N_BITS-1:0] product;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling, register file and switchover control.
  always_comb
  begin
    state_d = state_q;
    // Three stages; a level counts only once stages two and three agree.
    state_d.s1 = {sync_n, ref_select_pin, vco_in, secondary_reference, primary_reference};
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < NPIN; i++)
    begin
      if (state_q.s2[i] == state_q.s3[i])
      begin
        state_d.lvl[i] = state_q.s3[i];
      end
    end
    rise = state_d.lvl & ~state_q.lvl;
    fall = ~state_d.lvl & state_q.lvl;

    // Register writes; reset bits stay set until software clears them.
    if (reg_wr_en)
    begin
      case (reg_addr)
        prs_pkg::REF_DIV_LOW_ADDR: state_d.div_low = reg_wdata;
        prs_pkg::REF_DIV_HIGH_ADDR:
        begin
          state_d.div_high = {2'h0, reg_wdata[prs_pkg::REF_DIV_HIGH_BITS-1:0]};
        end
        prs_pkg::PRESCALER_CFG_ADDR: state_d.prescale_cfg = reg_wdata;
        prs_pkg::LOCK_OFFSET_CFG_ADDR: state_d.offset_cfg = reg_wdata;
        prs_pkg::REF_INPUT_CTRL_ADDR: state_d.ref_ctrl = reg_wdata;
        default: state_d.rdata = state_q.rdata;
      endcase
    end
    case (reg_addr)
      prs_pkg::REF_DIV_LOW_ADDR: state_d.rdata = state_q.div_low;
      prs_pkg::REF_DIV_HIGH_ADDR: state_d.rdata = state_q.div_high;
      prs_pkg::PRESCALER_CFG_ADDR: state_d.rdata = state_q.prescale_cfg;
      prs_pkg::LOCK_OFFSET_CFG_ADDR: state_d.rdata = state_q.offset_cfg;
      prs_pkg::REF_INPUT_CTRL_ADDR: state_d.rdata = state_q.ref_ctrl;
      default: state_d.rdata = 8'h00;
    endcase

    // Input power control; every enable bit clears at reset.
    pll_on = ~pll_power_down;
    state_d.diff_on = pll_on & state_q.ref_ctrl[prs_pkg::RC_DIFF_EN];
    state_d.pri_on = pll_on & state_q.ref_ctrl[prs_pkg::RC_PRIMARY_EN]
      & ~state_q.ref_ctrl[prs_pkg::RC_DIFF_EN];
    state_d.sec_on = pll_on & state_q.ref_ctrl[prs_pkg::RC_SECONDARY_EN]
      & ~state_q.ref_ctrl[prs_pkg::RC_DIFF_EN];
    state_d.xtal_on = state_q.ref_ctrl[prs_pkg::RC_CRYSTAL_EN];
    state_d.offset_on = state_q.offset_cfg[prs_pkg::LO_DC_OFFSET];

    dual_se = state_q.pri_on & state_q.sec_on;
    auto_mode = dual_se & state_q.ref_ctrl[prs_pkg::RC_AUTO];

    // Missing monitor: the secondary clock watches the primary.
    if (rise[PIN_PRI] | fall[PIN_PRI])
    begin
      state_d.miss_falls = 2'h0;
    end
    else if (fall[PIN_SEC] && state_q.miss_falls != prs_pkg::MISS_FALLS)
    begin
      state_d.miss_falls = state_q.miss_falls + 2'h1;
    end

    case (state_q.sw)
      prs_pkg::SW_PRIMARY:
      begin
        if (auto_mode && state_d.miss_falls == prs_pkg::MISS_FALLS)
        begin
          state_d.sw = prs_pkg::SW_MISSING;
        end
      end
      prs_pkg::SW_MISSING:
      begin
        if (!auto_mode)
        begin
          state_d.sw = prs_pkg::SW_PRIMARY;
        end
        else if (rise[PIN_SEC])
        begin
          state_d.sw = prs_pkg::SW_SECONDARY;
          state_d.return_rises = 3'h0;
          state_d.break_falls = 2'h0;
        end
      end
      prs_pkg::SW_SECONDARY:
      begin
        // Leaving automatic mode hands control back to manual selection.
        if (!auto_mode)
        begin
          state_d.sw = prs_pkg::SW_PRIMARY;
        end
        else if (!state_q.ref_ctrl[prs_pkg::RC_NONREVERTIVE])
        begin
          if (fall[PIN_SEC] && state_q.break_falls != prs_pkg::REVERT_BREAK_FALLS)
          begin
            state_d.break_falls = state_q.break_falls + 2'h1;
          end
          if (rise[PIN_PRI])
          begin
            if (state_d.break_falls == prs_pkg::REVERT_BREAK_FALLS)
            begin
              state_d.return_rises = 3'h1;
            end
            else
            begin
              state_d.return_rises = state_q.return_rises + 3'h1;
            end
            state_d.break_falls = 2'h0;
          end
          if (state_d.return_rises == prs_pkg::RETURN_RISES)
          begin
            state_d.sw = prs_pkg::SW_PRIMARY;
            state_d.miss_falls = 2'h0;
          end
        end
      end
      default: state_d.sw = prs_pkg::SW_PRIMARY;
    endcase

    // Selection source: automatic state, else register or pin.
    if (auto_mode)
    begin
      target_secondary = (state_d.sw == prs_pkg::SW_SECONDARY);
    end
    else
    begin
      target_secondary = dual_se & (state_q.ref_ctrl[prs_pkg::RC_MANUAL_SECONDARY]
        | state_q.lvl[PIN_SEL]);
    end

    // A change lands only on a rising edge of the new reference, so the
    // divider never sees a runt period. Disabling deglitch trades that
    // away for switching onto a dead input.
    new_ref_rise = target_secondary ? rise[PIN_SEC] : rise[PIN_PRI];
    if (target_secondary != state_q.active_secondary
        && (new_ref_rise || state_q.ref_ctrl[prs_pkg::RC_DEGLITCH_OFF]))
    begin
      state_d.active_secondary = target_secondary;
    end

    // Feedback ratio; counts out of range are clamped to a legal value.
    case (prs_pkg::prs_prescale_t'(state_q.prescale_cfg[prs_pkg::PS_MODE_LSB +: 3]))
      prs_pkg::PS_DM_2: modulus = 6'h02;
      prs_pkg::PS_DM_4: modulus = 6'h04;
      prs_pkg::PS_DM_8: modulus = 6'h08;
      prs_pkg::PS_DM_16: modulus = 6'h10;
      prs_pkg::PS_DM_32: modulus = 6'h20;
      prs_pkg::PS_FD_1: modulus = 6'h01;
      prs_pkg::PS_FD_2: modulus = 6'h02;
      prs_pkg::PS_FD_3: modulus = 6'h03;
      default: modulus = 6'h01;
    endcase
    fixed_divide = state_q.prescale_cfg[prs_pkg::PS_MODE_LSB +: 3] >= 3'(prs_pkg::PS_FD_1);
    if (main_bypass)
    begin
      main_eff = B_BITS'(1);
    end
    else if (main_count < prs_pkg::MIN_MAIN_COUNT)
    begin
      main_eff = prs_pkg::MIN_MAIN_COUNT;
    end
    else
    begin
      main_eff = main_count;
    end
    if (fixed_divide || main_bypass)
    begin
      swallow_eff = '0;
    end
    else if ({{(B_BITS - A_BITS){1'b0}}, swallow_count} >= main_eff)
    begin
      swallow_eff = A_BITS'(main_eff - B_BITS'(1));
    end
    else
    begin
      swallow_eff = swallow_count;
    end
    product = N_BITS'({{(N_BITS - B_BITS){1'b0}}, main_eff} * N_BITS'(modulus));
    state_d.fb_ratio = product + N_BITS'(swallow_eff);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
      state_q.s1 <= 5'h1f;
      state_q.s2 <= 5'h1f;
      state_q.s3 <= 5'h1f;
      state_q.lvl <= 5'h1f;
      state_q.div_low <= prs_pkg::REG_RESET_VALUE;
      state_q.div_high <= prs_pkg::REG_RESET_VALUE;
      state_q.prescale_cfg <= prs_pkg::REG_RESET_VALUE;
      state_q.offset_cfg <= prs_pkg::REG_RESET_VALUE;
      state_q.ref_ctrl <= prs_pkg::REG_RESET_VALUE;
      state_q.sw <= prs_pkg::SW_PRIMARY;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers. The VCO is sampled, so it must stay below a quarter of clk.
  assign sync_reset = sync_reset_enable & ~state_q.lvl[PIN_SYNC];
  assign ref_div.tick = state_q.diff_on ? rise[PIN_PRI]
    : (state_q.active_secondary ? rise[PIN_SEC] & state_q.sec_on
    : rise[PIN_PRI] & state_q.pri_on);
  assign ref_div.clr = state_q.prescale_cfg[prs_pkg::PS_RST_REF]
    | state_q.prescale_cfg[prs_pkg::PS_RST_SHARED] | sync_reset;
  assign ref_div.ratio = {state_q.div_high[prs_pkg::REF_DIV_HIGH_BITS-1:0], state_q.div_low};
  assign fb_div.tick = rise[PIN_VCO] & pll_on;
  assign fb_div.clr = state_q.prescale_cfg[prs_pkg::PS_RST_FB]
    | state_q.prescale_cfg[prs_pkg::PS_RST_SHARED] | sync_reset;
  assign fb_div.ratio = state_q.fb_ratio;

  prs_divider #(.W(R_BITS)) u_ref_divider (
    .clk(clk),
    .rst_n(rst_n),
    .div(ref_div.cnt)
  );

  prs_divider #(.W(N_BITS)) u_fb_divider (
    .clk(clk),
    .rst_n(rst_n),
    .div(fb_div.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign reg_rdata = state_q.rdata;
  assign diff_receiver_power_on = state_q.diff_on;
  assign primary_buffer_power_on = state_q.pri_on;
  assign secondary_buffer_power_on = state_q.sec_on;
  assign crystal_amplifier_enable = state_q.xtal_on;
  assign dc_offset_shift = state_q.offset_on;
  assign phase_detector_ref = ref_div.pulse;
  assign phase_detector_fb = fb_div.pulse;
  assign secondary_in_use = state_q.active_secondary;
  assign primary_missing = (state_q.sw != prs_pkg::SW_PRIMARY);

endmodule // prs_ref_switch

// [prs_ref_switch_monitor.sv]
// Checker on the top-level ports of the reference switch and divider block.
// Assumes a bind from the bench; everything here runs on clk.
`timescale 1ns/1ps
module prs_ref_switch_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic primary_reference,
  input wire logic secondary_reference,
  input wire logic pll_power_down,
  input wire logic diff_receiver_power_on,
  input wire logic primary_buffer_power_on,
  input wire logic secondary_buffer_power_on,
  input wire logic crystal_amplifier_enable,
  input wire logic dc_offset_shift,
  input wire logic phase_detector_ref,
  input wire logic phase_detector_fb,
  input wire logic secondary_in_use,
  input wire logic primary_missing
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Raw pin history; the block sees the same edges a few cycles later.
  logic prim_q;
  logic sec_q;
  logic [1:0] falls_q;
  logic [2:0] rises_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prim_q <= 1'b0;
      sec_q <= 1'b0;
      falls_q <= 2'h0;
      rises_q <= 3'h0;
    end
    else
    begin
      prim_q <= primary_reference;
      sec_q <= secondary_reference;
      if (prim_q != primary_reference)
        falls_q <= 2'h0;
      else if (sec_q && !secondary_reference && falls_q != 2'h3)
        falls_q <= falls_q + 2'h1;
      if (!primary_missing)
        rises_q <= 3'h0;
      else if (!prim_q && primary_reference && rises_q != 3'h7)
        rises_q <= rises_q + 3'h1;
    end
  end
  ////////////////////////////////////////
  // A write followed by a quiet cycle, so the field is not overwritten.
  sequence wr_s(logic [9:0] a);
    reg_wr_en && reg_addr == a ##1 !reg_wr_en;
  endsequence
  reset_inputs_off_a: assert property (
    !$past(rst_n) |-> !diff_receiver_power_on && !primary_buffer_power_on
      && !secondary_buffer_power_on) else $error("Input stage on after reset.");
  diff_excludes_single_a: assert property (
    diff_receiver_power_on |-> !primary_buffer_power_on && !secondary_buffer_power_on)
    else $error("Single-ended buffer on in differential mode.");
  powerdown_all_off_a: assert property (
    pll_power_down [*3] |=> !diff_receiver_power_on && !primary_buffer_power_on
      && !secondary_buffer_power_on) else $error("Input stage on while PLL is down.");
  ref_pulse_single_a: assert property (
    phase_detector_ref |=> !phase_detector_ref) else $error("Reference pulse too long.");
  fb_pulse_single_a: assert property (
    phase_detector_fb |=> !phase_detector_fb) else $error("Feedback pulse too long.");
  takeover_wait_a: assert property (
    $rose(primary_missing) |-> !secondary_in_use ##1 !secondary_in_use)
    else $error("Secondary taken before its next rising edge.");
  offset_follows_a: assert property (
    wr_s(prs_pkg::LOCK_OFFSET_CFG_ADDR) |=>
      dc_offset_shift == $past(reg_wdata[prs_pkg::LO_DC_OFFSET], 2))
    else $error("Offset output does not follow its bit.");
  crystal_follows_a: assert property (
    wr_s(prs_pkg::REF_INPUT_CTRL_ADDR) |=>
      crystal_amplifier_enable == $past(reg_wdata[prs_pkg::RC_CRYSTAL_EN], 2))
    else $error("Crystal amplifier does not follow its bit.");
  missing_detect_a: assert property (
    $rose(primary_missing) |-> falls_q >= 2'h2)
    else $error("Primary declared missing too early.");
  revert_count_a: assert property (
    $fell(primary_missing) |-> rises_q >= 3'h4)
    else $error("Return to primary before four rising edges.");
endmodule // prs_ref_switch_monitor

// [prs_ref_src.sv]
// Behavioural model of the two reference sources and the external VCO.
// Assumes the bench starts and stops each reference with a run input.
`timescale 1ns/1ps
module prs_ref_src #(
  parameter int P_HALF = 50,
  parameter int S_HALF = 60,
  parameter int V_HALF = 15
) (
  input wire logic prim_run,
  input wire logic sec_run,
  output logic primary_reference,
  output logic secondary_reference,
  output logic vco_in
);
  // A stopped source holds its last level, as a dead CMOS driver would.
  initial
  begin
    primary_reference = 1'b0;
    #1.3;
    forever
    begin
      #(P_HALF);
      if (prim_run)
        primary_reference = ~primary_reference;
    end
  end
  initial
  begin
    secondary_reference = 1'b0;
    #2.1;
    forever
    begin
      #(S_HALF);
      if (sec_run)
        secondary_reference = ~secondary_reference;
    end
  end
  // The VCO runs free and stays below a quarter of the system clock.
  initial
  begin
    vco_in = 1'b0;
    #0.7;
    forever #(V_HALF) vco_in = ~vco_in;
  end
endmodule // prs_ref_src

// [prs_ref_switch_bench.sv]
// Self-checking bench for the PLL reference switch and divider block.
// Assumes the package, design, monitor and source model are compiled first.
`timescale 1ns/1ps
module prs_ref_switch_bench;
  typedef struct {
    prs_pkg::prs_prescale_t mode;
    logic [12:0] b;
    logic [5:0] a;
    logic byp;
    int n;
  } prs_fb_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic primary_reference;
  logic secondary_reference;
  logic vco_in;
  logic ref_select_pin = 1'b0;
  logic sync_n = 1'b1;
  logic sync_reset_enable = 1'b0;
  logic pll_power_down = 1'b0;
  logic [5:0] swallow_count = 6'h00;
  logic [12:0] main_count = 13'h0003;
  logic main_bypass = 1'b0;
  logic diff_receiver_power_on;
  logic primary_buffer_power_on;
  logic secondary_buffer_power_on;
  logic crystal_amplifier_enable;
  logic dc_offset_shift;
  logic phase_detector_ref;
  logic phase_detector_fb;
  logic secondary_in_use;
  logic primary_missing;
  logic prim_run = 1'b1;
  logic sec_run = 1'b1;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  logic [13:0] r_tab [4] = '{14'h0000, 14'h0001, 14'h0003, 14'h0100};
  prs_fb_row_t rows [11] = '{
    '{prs_pkg::PS_DM_2, 13'h3, 6'h1, 1'b0, 7}, '{prs_pkg::PS_DM_4, 13'h3, 6'h1, 1'b0, 13},
    '{prs_pkg::PS_DM_8, 13'h3, 6'h0, 1'b0, 24}, '{prs_pkg::PS_DM_16, 13'h3, 6'h2, 1'b0, 50},
    '{prs_pkg::PS_DM_32, 13'h3, 6'h1, 1'b0, 97}, '{prs_pkg::PS_FD_1, 13'h3, 6'h0, 1'b0, 3},
    '{prs_pkg::PS_FD_2, 13'h3, 6'h2, 1'b0, 6}, '{prs_pkg::PS_FD_3, 13'h4, 6'h5, 1'b0, 12},
    '{prs_pkg::PS_DM_2, 13'h2, 6'h0, 1'b0, 6}, '{prs_pkg::PS_DM_2, 13'h3, 6'h5, 1'b0, 8},
    '{prs_pkg::PS_FD_1, 13'h0, 6'h0, 1'b1, 1}};
  always #2.5 clk = ~clk;
  prs_ref_src u_src (.prim_run, .sec_run, .primary_reference, .secondary_reference, .vco_in);
  prs_ref_switch u_dut (.clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata,
    .primary_reference, .secondary_reference, .vco_in, .ref_select_pin, .sync_n,
    .sync_reset_enable, .pll_power_down, .swallow_count, .main_count, .main_bypass,
    .diff_receiver_power_on, .primary_buffer_power_on, .secondary_buffer_power_on,
    .crystal_amplifier_enable, .dc_offset_shift, .phase_detector_ref, .phase_detector_fb,
    .secondary_in_use, .primary_missing);
  ////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d, mismatched %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    settle(1);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    settle(1);
    reg_wr_en = 1'b0;
  endtask
  task automatic chk_reg(input logic [9:0] a, input logic [7:0] e);
    settle(1);
    reg_addr = a;
    settle(2);
    chk_val("register", e, reg_rdata);
  endtask
  task automatic chk_sel(input logic e);
    settle(150);
    chk_val("secondary in use", e, secondary_in_use);
  endtask
  // Cycles between divider pulses; the earlier gaps absorb the change of setting.
  task automatic gap(input bit fb, input int cap, output int c);
    repeat (3)
    begin
      c = 0;
      do
      begin
        settle(1);
        c++;
      end while (!(fb ? phase_detector_fb : phase_detector_ref) && c < cap);
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    settle(6);
    rst_n = 1'b1;
    chk_val("power", 3'h0, {diff_receiver_power_on, primary_buffer_power_on,
      secondary_buffer_power_on});
    chk_reg(prs_pkg::REF_INPUT_CTRL_ADDR, prs_pkg::REG_RESET_VALUE);
    chk_reg(prs_pkg::PRESCALER_CFG_ADDR, prs_pkg::REG_RESET_VALUE);
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h01);
    foreach (rows[i])
    begin
      wr(prs_pkg::PRESCALER_CFG_ADDR, {5'h00, rows[i].mode});
      main_count = rows[i].b;
      swallow_count = rows[i].a;
      main_bypass = rows[i].byp;
      gap(1'b1, 2000, n);
      chk_val("feedback gap", rows[i].n * 6, n);
    end
    $display("test feedback done");
    foreach (r_tab[i])
    begin
      wr(prs_pkg::REF_DIV_LOW_ADDR, r_tab[i][7:0]);
      wr(prs_pkg::REF_DIV_HIGH_ADDR, {2'h0, r_tab[i][13:8]});
      gap(1'b0, 8000, n);
      chk_val("reference gap", (r_tab[i] < 14'h2 ? 1 : int'(r_tab[i])) * 20, n);
    end
    wr(prs_pkg::REF_DIV_HIGH_ADDR, 8'hff);
    chk_reg(prs_pkg::REF_DIV_HIGH_ADDR, 8'h3f);
    wr(prs_pkg::REF_DIV_HIGH_ADDR, 8'h00);
    wr(10'h3ff, 8'hff);
    chk_reg(10'h3ff, 8'h00);
    $display("test reference divider done");
    // The reset bits hold the counters until software clears them.
    wr(prs_pkg::PRESCALER_CFG_ADDR, 8'h20);
    gap(1'b0, 100, n);
    chk_val("ref held", 100, n);
    chk_reg(prs_pkg::PRESCALER_CFG_ADDR, 8'h20);
    wr(prs_pkg::PRESCALER_CFG_ADDR, 8'h80);
    gap(1'b1, 100, n);
    chk_val("fb held", 100, n);
    wr(prs_pkg::PRESCALER_CFG_ADDR, 8'h40);
    gap(1'b1, 100, n);
    chk_val("fb held", 100, n);
    wr(prs_pkg::PRESCALER_CFG_ADDR, 8'h00);
    sync_reset_enable = 1'b1;
    sync_n = 1'b0;
    gap(1'b0, 100, n);
    chk_val("ref synced", 100, n);
    sync_n = 1'b1;
    gap(1'b0, 200, n);
    chk_val("reference gap", 20, n);
    $display("test counter resets done");
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h03);
    settle(3);
    chk_val("power", 3'h3, {diff_receiver_power_on, primary_buffer_power_on,
      secondary_buffer_power_on});
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h07);
    settle(3);
    chk_val("power", 3'h4, {diff_receiver_power_on, primary_buffer_power_on,
      secondary_buffer_power_on});
    pll_power_down = 1'b1;
    settle(4);
    chk_val("power", 3'h0, {diff_receiver_power_on, primary_buffer_power_on,
      secondary_buffer_power_on});
    pll_power_down = 1'b0;
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h45);
    ref_select_pin = 1'b1;
    chk_sel(1'b0);
    chk_val("crystal", 1'b1, crystal_amplifier_enable);
    wr(prs_pkg::LOCK_OFFSET_CFG_ADDR, 8'h80);
    settle(3);
    chk_val("offset", 1'b1, dc_offset_shift);
    wr(prs_pkg::LOCK_OFFSET_CFG_ADDR, 8'h00);
    settle(3);
    chk_val("offset", 1'b0, dc_offset_shift);
    // The secondary is running before each manual move onto it but the last, which is made with deglitch off.
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h03);
    chk_sel(1'b1);
    ref_select_pin = 1'b0;
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h23);
    chk_sel(1'b1);
    $display("test input stage done");
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h03);
    chk_sel(1'b0);
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h13);
    prim_run = 1'b0;
    chk_sel(1'b1);
    chk_val("missing", 1'b1, primary_missing);
    gap(1'b0, 200, n);
    chk_val("reference gap", 24, n);
    prim_run = 1'b1;
    chk_sel(1'b0);
    gap(1'b0, 200, n);
    chk_val("reference gap", 20, n);
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h1b);
    prim_run = 1'b0;
    chk_sel(1'b1);
    prim_run = 1'b1;
    chk_sel(1'b1);
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h03);
    chk_sel(1'b0);
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'h13);
    chk_sel(1'b0);
    sec_run = 1'b0;
    wr(prs_pkg::REF_INPUT_CTRL_ADDR, 8'ha3);
    chk_sel(1'b1);
    $display("test switchover done");
    end_sim();
  end
  // The run needs about 110 us, so this span means a hang.
  initial
  begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // prs_ref_switch_bench

bind prs_ref_switch prs_ref_switch_monitor u_mon (.clk, .rst_n, .reg_wr_en, .reg_addr,
  .reg_wdata, .primary_reference, .secondary_reference, .pll_power_down,
  .diff_receiver_power_on, .primary_buffer_power_on, .secondary_buffer_power_on,
  .crystal_amplifier_enable, .dc_offset_shift, .phase_detector_ref, .phase_detector_fb,
  .secondary_in_use, .primary_missing);
